/* File: hdl/ttcrb_timer.sv */
// sixteen-bit timer with capture, auto-reload and baud generation
`timescale 1ns/100ps
`include "ttcrb_regs.svh"
`default_nettype none
module ttcrb_timer (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire ttcrb_pkg::ttcrb_ctrl_t ctrl_in,
    input wire logic irq_enable_in,
    input wire logic count_input_pin_in,
    input wire logic trigger_pin_in,
    input wire logic clear_overflow_flag_in,
    input wire logic clear_external_flag_in,
    input wire logic count_wr_in,
    input wire logic [15:0] count_data_in,
    input wire logic reload_wr_in,
    input wire logic [15:0] reload_data_in,
    output logic [7:0] count_low_byte_out,
    output logic [7:0] count_high_byte_out,
    output logic [7:0] reload_low_byte_out,
    output logic [7:0] reload_high_byte_out,
    output logic overflow_flag_out,
    output logic external_flag_out,
    output logic irq_out,
    output logic rx_tick_out,
    output logic tx_tick_out,
    output logic adc_trigger_out
);

    // ****************************************
    // helpers
    // ****************************************

    // falling edge between two successive synchronised samples
    function automatic logic fall_of(input logic prev, input logic cur);
        fall_of = prev & ~cur;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [15:0] count;
    logic [15:0] reload;
    logic overflow_flag;
    logic external_flag;
    logic [1:0] cnt_sync;
    logic cnt_prev;
    logic [1:0] trg_sync;
    logic trg_prev;
    logic [3:0] div12_cnt;
    logic div2_phase;
    logic ext_half;
    ttcrb_pkg::ttcrb_mode_t mode;
    logic cnt_fall;
    logic trg_fall;
    logic tick;
    logic ovf;
    logic trg_evt;
    logic cap_evt;
    logic force_reload;
    logic [15:0] next_count;

    // ****************************************
    // mode decode
    // ****************************************

    // baud selects outrank capture select; run off wins over all
    always_comb begin
        if (!ctrl_in.run_bit) begin
            mode = ttcrb_pkg::TTCRB_OFF;
        end else if (ctrl_in.receive_baud_select || ctrl_in.transmit_baud_select) begin
            mode = ttcrb_pkg::TTCRB_BAUD;
        end else if (ctrl_in.capture_reload_select) begin
            mode = ttcrb_pkg::TTCRB_CAPTURE;
        end else begin
            mode = ttcrb_pkg::TTCRB_RELOAD;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************

    // two flops per pin, then one more stage kept for edge compare
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_sync <= 2'h3;
            cnt_prev <= 1'b1;
        end else begin
            cnt_sync <= {cnt_sync[0], count_input_pin_in};
            cnt_prev <= cnt_sync[1];
        end
    end

    // the trigger pin has its own chain, same depth
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trg_sync <= 2'h3;
            trg_prev <= 1'b1;
        end else begin
            trg_sync <= {trg_sync[0], trigger_pin_in};
            trg_prev <= trg_sync[1];
        end
    end

    // only the second stage and its delayed copy are compared
    assign cnt_fall = fall_of(cnt_prev, cnt_sync[1]);
    assign trg_fall = fall_of(trg_prev, trg_sync[1]);

    // ****************************************
    // prescalers
    // ****************************************

    // free-running divide by twelve; first tick may be short after run
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div12_cnt <= `TTCRB_DIV12_RST;
        end else if (div12_cnt == `TTCRB_DIV12_LAST) begin
            div12_cnt <= `TTCRB_DIV12_RST;
        end else begin
            div12_cnt <= div12_cnt + 4'h1;
        end
    end

    // divide by two for the baud time base
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div2_phase <= 1'b0;
        end else begin
            div2_phase <= ~div2_phase;
        end
    end

    // pin edges are halved in baud mode so the uart sees pin over 32 per span
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_half <= 1'b0;
        end else if (mode != ttcrb_pkg::TTCRB_BAUD) begin
            ext_half <= 1'b0;
        end else if (ctrl_in.count_source_select && cnt_fall) begin
            ext_half <= ~ext_half;
        end
    end

    // ****************************************
    // count tick selection
    // ****************************************

    // one increment request per selected source event, except in baud mode where only every second one counts
    always_comb begin
        tick = 1'b0;
        if (mode == ttcrb_pkg::TTCRB_BAUD) begin
            if (ctrl_in.count_source_select) begin
                tick = cnt_fall && ext_half;
            end else begin
                tick = div2_phase;
            end
        end else if (mode != ttcrb_pkg::TTCRB_OFF) begin
            if (ctrl_in.count_source_select) begin
                tick = cnt_fall;
            end else if (ctrl_in.prescale_select) begin
                tick = 1'b1;
            end else begin
                tick = (div12_cnt == `TTCRB_DIV12_LAST);
            end
        end
    end

    // wrap from all ones is the overflow event
    assign ovf = tick && (count == `TTCRB_COUNT_MAX);

    // trigger edges count only while enabled and running
    assign trg_evt = trg_fall && ctrl_in.external_enable && (mode != ttcrb_pkg::TTCRB_OFF);
    assign cap_evt = trg_evt && (mode == ttcrb_pkg::TTCRB_CAPTURE);
    assign force_reload = trg_evt && (mode == ttcrb_pkg::TTCRB_RELOAD);

    // ****************************************
    // counter
    // ****************************************

    // reload modes load the pair on overflow, capture mode wraps to zero
    always_comb begin
        next_count = count;
        if (force_reload) begin
            next_count = reload;
        end else if (ovf && (mode == ttcrb_pkg::TTCRB_CAPTURE)) begin
            next_count = `TTCRB_COUNT_RST;
        end else if (ovf) begin
            next_count = reload;
        end else if (tick) begin
            next_count = count + 16'h0001;
        end
    end

    // a software write wins over any count activity in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= `TTCRB_COUNT_RST;
        end else if (count_wr_in) begin
            count <= count_data_in;
        end else begin
            count <= next_count;
        end
    end

    // ****************************************
    // capture / reload pair
    // ****************************************

    // a capture wins over a software write so a measured edge is not lost
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reload <= `TTCRB_RELOAD_RST;
        end else if (cap_evt) begin
            reload <= count;
        end else if (reload_wr_in) begin
            reload <= reload_data_in;
        end
    end

    // ****************************************
    // flags
    // ****************************************

    // overflow flag: set beats clear, never set in baud mode
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            overflow_flag <= 1'b0;
        end else if (ovf && (mode != ttcrb_pkg::TTCRB_BAUD)) begin
            overflow_flag <= 1'b1;
        end else if (clear_overflow_flag_in) begin
            overflow_flag <= 1'b0;
        end
    end

    // external flag: any enabled trigger edge while running, sticky
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            external_flag <= 1'b0;
        end else if (trg_evt) begin
            external_flag <= 1'b1;
        end else if (clear_external_flag_in) begin
            external_flag <= 1'b0;
        end
    end

    // ****************************************
    // uart ticks and converter trigger
    // ****************************************

    // registered one-cycle pulses; the uart does the divide by sixteen
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_tick_out <= 1'b0;
            tx_tick_out <= 1'b0;
        end else begin
            rx_tick_out <= ovf && (mode == ttcrb_pkg::TTCRB_BAUD)
                && ctrl_in.receive_baud_select;
            tx_tick_out <= ovf && (mode == ttcrb_pkg::TTCRB_BAUD)
                && ctrl_in.transmit_baud_select;
        end
    end

    // every overflow is offered to the converter, baud mode included
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            adc_trigger_out <= 1'b0;
        end else begin
            adc_trigger_out <= ovf;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign count_low_byte_out = count[7:0];
    assign count_high_byte_out = count[15:8];
    assign reload_low_byte_out = reload[7:0];
    assign reload_high_byte_out = reload[15:8];
    assign overflow_flag_out = overflow_flag;
    assign external_flag_out = external_flag;
    // interrupt is a level while either flag is held and enabled
    assign irq_out = irq_enable_in && (overflow_flag || external_flag);

    // ****************************************
    // checks
    // ****************************************
    default clocking chk_clk @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    chk_capture_value: assert property (
        cap_evt |=> ({reload_high_byte_out, reload_low_byte_out} == $past(count)))
        else $error("capture did not copy the count");

    chk_reload_load: assert property (
        (ovf && mode == ttcrb_pkg::TTCRB_RELOAD && !count_wr_in)
        |=> (count == $past(reload)))
        else $error("overflow did not reload the count");

    chk_capture_wrap: assert property (
        (ovf && mode == ttcrb_pkg::TTCRB_CAPTURE && !count_wr_in && !force_reload)
        |=> (count == 16'h0000) ##0 overflow_flag_out)
        else $error("capture mode wrap wrong");

    chk_baud_noflag: assert property (
        (mode == ttcrb_pkg::TTCRB_BAUD && !overflow_flag_out) |=> !overflow_flag_out)
        else $error("overflow flag set in baud mode");

    chk_baud_ticks: assert property (
        (ovf && mode == ttcrb_pkg::TTCRB_BAUD)
        |=> (rx_tick_out == $past(ctrl_in.receive_baud_select))
        && (tx_tick_out == $past(ctrl_in.transmit_baud_select)))
        else $error("baud tick routing wrong");

    chk_trigger_ignored: assert property (
        (!ctrl_in.external_enable && !external_flag_out) |=> !external_flag_out)
        else $error("trigger acted while disabled");

    chk_run_stop: assert property (
        (!ctrl_in.run_bit && !count_wr_in) |=> $stable(count))
        else $error("count moved while stopped");

    chk_div12_pace: assert property (
        (tick && mode != ttcrb_pkg::TTCRB_BAUD && !ctrl_in.count_source_select
        && !ctrl_in.prescale_select) |-> (div12_cnt == 4'hB))
        else $error("divide by twelve tick out of step");

    chk_ext_sticky: assert property (
        (external_flag_out && !clear_external_flag_in) |=> external_flag_out)
        else $error("external flag dropped without clear");

    chk_edge_once: assert property (
        trg_fall |=> !trg_fall)
        else $error("trigger edge seen twice");

    cov_capture: cover property (cap_evt);
    cov_reload_trigger: cover property (force_reload ##1 external_flag_out);
    cov_baud_rx: cover property (rx_tick_out);
    cov_flag_race: cover property (ovf && clear_overflow_flag_in);

endmodule // ttcrb_timer
`default_nettype wire

/* File: shared/ttcrb_regs.svh */
// constants for the two-capture-reload-baud timer
// Notes on behaviour
// - the count is sixteen bits, made of a low byte and a high byte
// - internal source counts the system clock divided by one or twelve
// - external source counts once per falling edge on the count pin
// - capture mode needs both baud selects clear, capture select set, run set
// - a trigger falling edge copies the full count into the reload pair
// - captures happen only with external enable set; otherwise trigger is ignored
// - in capture and reload modes a wrap sets the overflow flag and interrupt
// - reload mode when capture select and baud selects clear; run off stops all
// - in reload mode each overflow loads the reload pair into the count
// - in reload mode with external enable, a trigger edge forces a reload
// - either baud select gives baud mode, reloading whatever capture select holds
// - in baud mode overflows set no flag and become uart shift ticks
// - receive select routes ticks to receive, transmit select to transmit
// - baud mode internal source is system clock over two, prescale ignored
// - baud mode external source gives bit rate pin frequency over 32 times span
// - baud mode with external enable: trigger edge sets external flag and interrupt
// - timer events are offered as a converter start trigger
// - external flag set by a trigger capture, a forced reload or a baud-mode trigger edge; held until software clears
// - prescale select: zero gives divide by twelve, one gives undivided clock
`ifndef TTCRB_REGS_SVH
`define TTCRB_REGS_SVH

// ****************************************
// widths and reset values
// ****************************************
`define TTCRB_BYTE_W 8
`define TTCRB_COUNT_W 16
`define TTCRB_COUNT_RST 16'h0000
`define TTCRB_RELOAD_RST 16'h0000
`define TTCRB_COUNT_MAX 16'hFFFF

// ****************************************
// prescaler counts
// ****************************************
`define TTCRB_DIV12_LAST 4'hB
`define TTCRB_DIV12_RST 4'h0

`endif

/* File: shared/ttcrb_pkg.sv */
// types shared by the two-capture-reload-baud timer
`default_nettype none
package ttcrb_pkg;

    // ****************************************
    // control bits driven by software
    // ****************************************
    typedef struct packed {
        logic run_bit;
        logic count_source_select;
        logic capture_reload_select;
        logic external_enable;
        logic receive_baud_select;
        logic transmit_baud_select;
        logic prescale_select;
    } ttcrb_ctrl_t;

    // ****************************************
    // operating modes
    // ****************************************
    typedef enum logic [1:0] {
        TTCRB_OFF = 2'b00,
        TTCRB_CAPTURE = 2'b01,
        TTCRB_RELOAD = 2'b10,
        TTCRB_BAUD = 2'b11
    } ttcrb_mode_t;

endpackage
`default_nettype wire

/* File: sim/ttcrb_uart_model.sv */
// uart shift-clock model that consumes the timer baud ticks
`timescale 1ns/100ps
`default_nettype none
module ttcrb_uart_model #(
    parameter int UART_MODE = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic rx_tick_in,
    input wire logic tx_tick_in,
    output logic [7:0] rx_bits_out,
    output logic [7:0] tx_bits_out
);
    logic [3:0] rx_div;
    logic [3:0] tx_div;
    // sixteen ticks make one bit time; baud ticks are only taken in modes 1 and 3
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_div <= 4'h0;
            tx_div <= 4'h0;
            rx_bits_out <= 8'h00;
            tx_bits_out <= 8'h00;
        end else if (UART_MODE == 1 || UART_MODE == 3) begin
            if (rx_tick_in) begin
                rx_div <= rx_div + 4'h1;
                if (rx_div == 4'hF) rx_bits_out <= rx_bits_out + 8'h01;
            end
            if (tx_tick_in) begin
                tx_div <= tx_div + 4'h1;
                if (tx_div == 4'hF) tx_bits_out <= tx_bits_out + 8'h01;
            end
        end
    end
endmodule // ttcrb_uart_model
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the capture, reload and baud timer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    ttcrb_pkg::ttcrb_ctrl_t ctrl = '0;
    logic irq_en = 1'b0;
    logic cpin = 1'b1;
    logic trig = 1'b1;
    logic clr_ov = 1'b0;
    logic clr_ex = 1'b0;
    logic wr = 1'b0;
    logic [15:0] cdat = 16'h0000;
    logic [15:0] rdat = 16'h0000;
    logic [7:0] cl, ch, rl, rh, rxb, txb;
    logic ovf, exf, irq, rxt, txt, adc;
    logic [15:0] cnt;
    logic [15:0] rld;
    int fails = 0;
    int n_checks = 0;
    assign cnt = {ch, cl};
    assign rld = {rh, rl};
    always #10 clk_in = ~clk_in;

    ttcrb_timer uut (.clk_in(clk_in), .resetn_in(resetn_in), .ctrl_in(ctrl),
        .irq_enable_in(irq_en), .count_input_pin_in(cpin), .trigger_pin_in(trig),
        .clear_overflow_flag_in(clr_ov), .clear_external_flag_in(clr_ex),
        .count_wr_in(wr), .count_data_in(cdat), .reload_wr_in(wr), .reload_data_in(rdat),
        .count_low_byte_out(cl), .count_high_byte_out(ch), .reload_low_byte_out(rl),
        .reload_high_byte_out(rh), .overflow_flag_out(ovf), .external_flag_out(exf),
        .irq_out(irq), .rx_tick_out(rxt), .tx_tick_out(txt), .adc_trigger_out(adc));
    ttcrb_uart_model #(.UART_MODE(1)) partner (.clk_in(clk_in), .resetn_in(resetn_in),
        .rx_tick_in(rxt), .tx_tick_in(txt), .rx_bits_out(rxb), .tx_bits_out(txb));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // sample one time unit after the edge so the design updates have landed
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic load(input logic [15:0] c, input logic [15:0] r);
        wr <= 1'b1;
        cdat <= c;
        rdat <= r;
        cyc(1);
        wr <= 1'b0;
    endtask
    function automatic logic sig(input int w);
        return (w == 0) ? ovf : (w == 1) ? exf : (w == 2) ? rxt : txt;
    endfunction
    // bounded wait; running out ends the run as a failure
    task automatic wait_sig(input int w, input int lim);
        int i;
        for (i = 0; i < lim && sig(w) !== 1'b1; i++) cyc(1);
        if (sig(w) !== 1'b1) begin
            fails++;
            $display("[ERR] %0t wait ran out on signal %0d", $time, w);
            tally_and_finish();
        end
    endtask
    // a falling edge held low long enough to pass the synchroniser
    task automatic fall(input logic on_trig);
        if (on_trig) trig <= 1'b0;
        else cpin <= 1'b0;
        cyc(4);
        trig <= 1'b1;
        cpin <= 1'b1;
        cyc(4);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reload();
        logic [15:0] held;
        load(16'hFFFD, 16'hFFFE);
        irq_en <= 1'b1;
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h41);
        wait_sig(0, 10);
        chk(cnt, 16'hFFFE);
        chk(adc, 1'b1);
        chk(irq, 1'b1);
        cyc(1);
        chk(adc, 1'b0);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h01);
        clr_ov <= 1'b1;
        cyc(1);
        clr_ov <= 1'b0;
        cyc(2);
        chk(ovf, 1'b0);
        chk(irq, 1'b0);
        held = cnt;
        cyc(5);
        chk(cnt, held);
        $display("test reload done");
    endtask
    task automatic t_rates();
        load(16'h0000, 16'h0000);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h41);
        cyc(20);
        chk(cnt, 16'h0014);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h00);
        load(16'h0000, 16'h0000);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h40);
        cyc(120);
        chk(cnt, 16'h000A);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h60);
        load(16'h0000, 16'h0000);
        repeat (5) fall(1'b0);
        chk(cnt, 16'h0005);
        $display("test rates done");
    endtask
    task automatic t_capture();
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h51);
        load(16'h1234, 16'h0000);
        fall(1'b1);
        chk(rld, 16'h0000);
        chk(exf, 1'b0);
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h59);
        trig <= 1'b0;
        wait_sig(1, 8);
        chk(rld, cnt - 16'h0001);
        trig <= 1'b1;
        cyc(10);
        chk(exf, 1'b1);
        // capture mode wrap goes to zero and raises the overflow flag
        load(16'hFFFE, 16'h0000);
        wait_sig(0, 8);
        chk(cnt, 16'h0000);
        clr_ov <= 1'b1;
        clr_ex <= 1'b1;
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h49);
        load(16'h0000, 16'h1234);
        clr_ov <= 1'b0;
        clr_ex <= 1'b0;
        cyc(2);
        chk(exf, 1'b0);
        chk(ovf, 1'b0);
        trig <= 1'b0;
        wait_sig(1, 8);
        chk((cnt - 16'h1234) <= 16'h0001, 1'b1);
        trig <= 1'b1;
        $display("test capture done");
    endtask
    task automatic t_baud();
        logic [6:0] modes[3] = '{7'h44, 7'h42, 7'h5E};
        logic srx, stx, sov;
        logic [7:0] r0, t0;
        int n;
        load(16'hFFF0, 16'hFFF0);
        foreach (modes[m]) begin
            ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(modes[m]);
            wait_sig(modes[m][2] ? 2 : 3, 80);
            {srx, stx, sov} = 3'b000;
            for (n = 1; n < 80; n++) begin
                cyc(1);
                srx |= rxt;
                stx |= txt;
                sov |= ovf;
                if (sig(modes[m][2] ? 2 : 3) === 1'b1) break;
            end
            chk(n, 16'h0020);
            chk({srx, stx}, modes[m][2:1]);
            chk(sov, 1'b0);
        end
        r0 = rxb;
        t0 = txb;
        cyc(512);
        chk(rxb - r0, 8'h01);
        chk(txb - t0, 8'h01);
        // flag left over from the capture test must go first
        clr_ex <= 1'b1;
        cyc(1);
        clr_ex <= 1'b0;
        chk(exf, 1'b0);
        chk(irq, 1'b0);
        // external source in baud mode: two pin falls per count step
        ctrl <= ttcrb_pkg::ttcrb_ctrl_t'(7'h6C);
        load(16'h0000, 16'h0000);
        repeat (4) fall(1'b0);
        chk(cnt, 16'h0002);
        fall(1'b1);
        chk(exf, 1'b1);
        chk(irq, 1'b1);
        $display("test baud done");
    endtask

    initial begin
        cyc(10);
        resetn_in <= 1'b1;
        cyc(2);
        chk(ovf, 1'b0);
        t_reload();
        t_rates();
        t_capture();
        t_baud();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
